// ---- rtl/arsb_device.sv ----
/*
 Drive end: reset handling, task registers, translation and address checks.
 Assumes media, diagnostics, cache and head actuator sit on the user ports.
*/
// The AXI4-Lite register port and the register offsets are this design's own decisions.
// Notes on behaviour
// - Power-on: init, diagnose, spin, defaults, timer
// - Link reset: abort, registers, timer; no diagnostics
// - Soft reset on bit set then cleared
// - Abort pulsed at once; registers load only after write cache flushed
// - Soft reset reverts settings only if enabled
// - Reset in sleep goes to standby
// - Load default task register values on reset
// - Error register carries diagnostic codes 01h-05h
// - Error reads 01h pass, else failing code
// - Max-address security cleared only at power-on
// - Standby and sleep unload heads before completing
// - Host puts drive in standby before removing power
// - Device/head bit 6 selects linear addressing
// - Sector, head, cylinder limits checked per translation
// - Init parameters recompute logical cylinder count
// - Block address from cylinder, head, sector
// - Linear address spread over four registers
// - Default and current translation reported
// - Status reset value sets ready and seek
`timescale 1ns/10ps
`default_nettype none
module arsb_device
	import arsb_pkg::*;
#(
	parameter logic [27:0] CAPACITY = DEF_CAPACITY
)
(
	input wire logic aclk,
	input wire logic aresetn,
	arsb_if.dev lnk,
	input wire logic power_up_standby,
	input wire logic [7:0] diag_code,
	input wire logic diag_done,
	input wire logic cache_dirty,
	input wire logic unload_done,
	output logic diag_req,
	output logic flush_req,
	output logic unload_req,
	output logic hw_init,
	output logic spin_up,
	output logic timer_reset,
	output logic setmax_clear,
	output logic settings_revert,
	output logic abort_host,
	output var arsb_pmode_e power_mode,
	output logic media_req,
	output logic [7:0] media_cmd,
	output logic [27:0] media_lba,
	output logic [7:0] cur_spt,
	output logic [4:0] cur_hpc,
	output logic [15:0] cur_cyl,
	output logic [7:0] def_spt,
	output logic [4:0] def_hpc,
	output logic [15:0] def_cyl
);
	typedef enum logic [7:0] {
		S_POR = 8'h01,
		S_DIAG = 8'h02,
		S_FLUSH = 8'h04,
		S_LOAD = 8'h08,
		S_CYL = 8'h10,
		S_READY = 8'h20,
		S_UNLD = 8'h40,
		S_XLAT = 8'h80
	} arsb_dstate_e;

	typedef struct packed {
		arsb_dstate_e st;
		arsb_kind_e kind;
		arsb_pmode_e pmode;
		logic [7:0] err;
		logic [7:0] diag_last;
		logic [7:0] cnt;
		logic [7:0] a0;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] dh;
		logic [7:0] feat;
		logic [7:0] stat;
		logic [7:0] cmd;
		logic software_reset_bit;
		logic revert_en;
		logic [7:0] spt;
		logic [4:0] hpc;
		logic [15:0] cyl;
		logic [15:0] dcyl;
		logic [27:0] rem;
		logic [7:0] rdata;
		logic rvalid;
		logic hw_init;
		logic spin_up;
		logic timer_reset;
		logic setmax_clear;
		logic settings_revert;
		logic abort_host;
		logic media_req;
		logic [27:0] media_lba;
	} arsb_dev_s;

	arsb_dev_s d;
	arsb_dev_s next_d;
	logic busy;
	logic [12:0] prod;
	logic [27:0] lba;
	logic chs_ok;

	assign busy = d.st != S_READY;
	assign prod = {5'h00, d.spt} * {8'h00, d.hpc};
	assign lba = d.dh[DH_LBA_BIT] ? {d.dh[3:0], d.a2, d.a1, d.a0}
		: arsb_chs2lba({d.a2, d.a1}, d.dh[3:0], d.a0, d.hpc, d.spt);
	assign chs_ok = d.a0 != 8'h00 && d.a0 <= d.spt && {1'b0, d.dh[3:0]} < d.hpc
		&& {d.a2, d.a1} < d.cyl;

	always_comb
	begin
		next_d = d;
		next_d.rvalid = 1'b0;
		next_d.hw_init = 1'b0;
		next_d.spin_up = 1'b0;
		next_d.timer_reset = 1'b0;
		next_d.setmax_clear = 1'b0;
		next_d.settings_revert = 1'b0;
		next_d.abort_host = 1'b0;
		next_d.media_req = 1'b0;
		if (lnk.rd)
		begin
			next_d.rvalid = 1'b1;
			// While busy every address answers with status
			if (busy)
				next_d.rdata = {1'b1, d.stat[6:0]};
			else if (lnk.addr == A_ERR)
				next_d.rdata = d.err;
			else if (lnk.addr == A_CNT)
				next_d.rdata = d.cnt;
			else if (lnk.addr == A_AD0)
				next_d.rdata = d.a0;
			else if (lnk.addr == A_AD1)
				next_d.rdata = d.a1;
			else if (lnk.addr == A_AD2)
				next_d.rdata = d.a2;
			else if (lnk.addr == A_DH)
				next_d.rdata = d.dh;
			else if (lnk.addr == A_STCMD || lnk.addr == A_ALTCTL)
				next_d.rdata = d.stat;
			else
				next_d.rdata = 8'h00;
		end
		case (d.st)
			S_POR:
			begin
				next_d.hw_init = 1'b1;
				next_d.setmax_clear = 1'b1;
				next_d.timer_reset = 1'b1;
				next_d.spin_up = !power_up_standby;
				next_d.pmode = power_up_standby ? PM_STBY : PM_IDLE;
				next_d.kind = K_POR;
				next_d.st = S_DIAG;
			end
			S_DIAG:
				if (diag_done)
				begin
					next_d.diag_last = diag_code;
					next_d.err = diag_code;
					next_d.stat = RST_STAT;
					next_d.st = d.kind == K_POR ? S_LOAD : S_READY;
				end
			S_FLUSH:
				if (!cache_dirty)
					next_d.st = S_LOAD;
			S_LOAD:
			begin
				next_d.cnt = RST_CNT;
				next_d.a0 = RST_AD0;
				next_d.a1 = RST_AD1;
				next_d.a2 = RST_AD2;
				next_d.dh = RST_DH;
				next_d.stat = RST_STAT;
				next_d.err = d.diag_last;
				if (d.pmode == PM_SLEEP)
					next_d.pmode = PM_STBY;
				if (d.kind == K_POR || d.revert_en)
				begin
					next_d.settings_revert = 1'b1;
					next_d.spt = DEF_SPT;
					next_d.hpc = DEF_HPC;
					next_d.cyl = 16'h0000;
					next_d.rem = CAPACITY;
					next_d.st = S_CYL;
				end
				else
					next_d.st = S_READY;
			end
			S_CYL:
				// One cylinder per cycle; trades speed for no divider
				if (prod != 13'h0000 && d.rem >= {15'h0000, prod} && d.cyl != MAX_CYL)
				begin
					next_d.rem = d.rem - {15'h0000, prod};
					next_d.cyl = d.cyl + 16'h0001;
				end
				else
				begin
					if (d.spt == DEF_SPT && d.hpc == DEF_HPC)
						next_d.dcyl = d.cyl;
					next_d.st = S_READY;
				end
			S_UNLD:
				if (unload_done && !cache_dirty)
				begin
					next_d.pmode = d.cmd == CMD_SLEEP ? PM_SLEEP : PM_STBY;
					next_d.stat = RST_STAT;
					next_d.st = S_READY;
				end
			S_XLAT:
			begin
				next_d.st = S_READY;
				if (d.dh[DH_LBA_BIT] || chs_ok)
				begin
					next_d.media_req = 1'b1;
					next_d.media_lba = lba;
					next_d.stat = RST_STAT;
				end
				else
				begin
					next_d.err = ERR_ABORT;
					next_d.stat = STAT_ERR;
				end
			end
			S_READY:
				// Sleeping interface ignores register writes but a reset; reads still answer
				if (lnk.wr && d.pmode != PM_SLEEP)
				begin
					if (lnk.addr == A_ERR)
						next_d.feat = lnk.wdata;
					else if (lnk.addr == A_CNT)
						next_d.cnt = lnk.wdata;
					else if (lnk.addr == A_AD0)
						next_d.a0 = lnk.wdata;
					else if (lnk.addr == A_AD1)
						next_d.a1 = lnk.wdata;
					else if (lnk.addr == A_AD2)
						next_d.a2 = lnk.wdata;
					else if (lnk.addr == A_DH)
						next_d.dh = lnk.wdata;
					else if (lnk.addr == A_STCMD)
					begin
						next_d.cmd = lnk.wdata;
						next_d.stat = {d.stat[7:1], 1'b0};
						case (lnk.wdata)
							CMD_DIAG:
							begin
								next_d.kind = K_DIAG;
								next_d.st = S_DIAG;
							end
							CMD_INITP:
								if (d.cnt != 8'h00)
								begin
									next_d.spt = d.cnt;
									next_d.hpc = 5'({1'b0, d.dh[3:0]} + 5'h01);
									next_d.cyl = 16'h0000;
									next_d.rem = CAPACITY;
									next_d.st = S_CYL;
								end
								else
								begin
									next_d.err = ERR_ABORT;
									next_d.stat = STAT_ERR;
								end
							CMD_SETF:
							begin
								if (d.feat == FEAT_REVERT_ON)
									next_d.revert_en = 1'b1;
								else if (d.feat == FEAT_REVERT_OFF)
									next_d.revert_en = 1'b0;
								next_d.stat = RST_STAT;
							end
							CMD_STBY, CMD_STBYI, CMD_SLEEP:
								next_d.st = S_UNLD;
							CMD_IDLE:
							begin
								next_d.pmode = PM_IDLE;
								next_d.stat = RST_STAT;
							end
							default:
								next_d.st = S_XLAT;
						endcase
					end
				end
			default:
				next_d.st = S_POR;
		endcase
		if (lnk.wr && lnk.addr == A_ALTCTL)
			next_d.software_reset_bit = lnk.wdata[CTL_SOFTWARE_RESET_BIT_BIT];
		// Resets override whatever the state machine chose
		if (lnk.link_rst || (lnk.wr && lnk.addr == A_ALTCTL && d.software_reset_bit && !lnk.wdata[CTL_SOFTWARE_RESET_BIT_BIT]))
		begin
			next_d.kind = lnk.link_rst ? K_LINK : K_SOFT;
			next_d.timer_reset = lnk.link_rst;
			next_d.abort_host = 1'b1;
			next_d.stat = {1'b1, d.stat[6:0]};
			next_d.st = S_FLUSH;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			d <= '0;
			d.st <= S_POR;
		end
		else
			d <= next_d;
	end

	assign lnk.rdata = d.rdata;
	assign lnk.rvalid = d.rvalid;
	assign diag_req = d.st == S_DIAG;
	assign flush_req = d.st == S_FLUSH || d.st == S_UNLD;
	assign unload_req = d.st == S_UNLD && !cache_dirty;
	assign hw_init = d.hw_init;
	assign spin_up = d.spin_up;
	assign timer_reset = d.timer_reset;
	assign setmax_clear = d.setmax_clear;
	assign settings_revert = d.settings_revert;
	assign abort_host = d.abort_host;
	assign power_mode = d.pmode;
	assign media_req = d.media_req;
	assign media_cmd = d.cmd;
	assign media_lba = d.media_lba;
	assign cur_spt = d.spt;
	assign cur_hpc = d.hpc;
	assign cur_cyl = d.cyl;
	assign def_spt = DEF_SPT;
	assign def_hpc = DEF_HPC;
	assign def_cyl = d.dcyl;
endmodule // arsb_device
`default_nettype wire

// ---- rtl/arsb_pkg.sv ----
/*
 Constants, types and helpers shared by both ends of the task-register link.
 Assumes one clock of 20 MHz shared by both ends.
*/
`default_nettype none
package arsb_pkg;
	// Task register addresses on the link
	localparam logic [3:0] A_ERR = 4'h1;
	localparam logic [3:0] A_CNT = 4'h2;
	localparam logic [3:0] A_AD0 = 4'h3;
	localparam logic [3:0] A_AD1 = 4'h4;
	localparam logic [3:0] A_AD2 = 4'h5;
	localparam logic [3:0] A_DH = 4'h6;
	localparam logic [3:0] A_STCMD = 4'h7;
	localparam logic [3:0] A_ALTCTL = 4'h8;
	// Values after any reset, then status and error codes and bit positions
	localparam logic [7:0] RST_CNT = 8'h01;
	localparam logic [7:0] RST_AD0 = 8'h01;
	localparam logic [7:0] RST_AD1 = 8'h00;
	localparam logic [7:0] RST_AD2 = 8'h00;
	localparam logic [7:0] RST_DH = 8'h00;
	localparam logic [7:0] RST_STAT = 8'h50;
	localparam logic [7:0] STAT_ERR = 8'h51;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] DIAG_OK = 8'h01;
	localparam logic [7:0] DIAG_FMT = 8'h02;
	localparam logic [7:0] DIAG_BUF = 8'h03;
	localparam logic [7:0] DIAG_ECC = 8'h04;
	localparam logic [7:0] DIAG_CPU = 8'h05;
	localparam int BSY_BIT = 7;
	localparam int DH_LBA_BIT = 6;
	localparam int CTL_SOFTWARE_RESET_BIT_BIT = 2;
	localparam logic [7:0] CTL_SOFTWARE_RESET_BIT_ON = 8'h04;
	localparam logic [7:0] CTL_SOFTWARE_RESET_BIT_OFF = 8'h00;
	// Commands and set-features codes
	localparam logic [7:0] CMD_DIAG = 8'h90;
	localparam logic [7:0] CMD_INITP = 8'h91;
	localparam logic [7:0] CMD_SETF = 8'hEF;
	localparam logic [7:0] CMD_STBY = 8'hE2;
	localparam logic [7:0] CMD_STBYI = 8'hE0;
	localparam logic [7:0] CMD_SLEEP = 8'hE6;
	localparam logic [7:0] CMD_IDLE = 8'hE3;
	localparam logic [7:0] FEAT_REVERT_ON = 8'hCC;
	localparam logic [7:0] FEAT_REVERT_OFF = 8'h66;
	// Translation
	localparam logic [7:0] DEF_SPT = 8'h3F;
	localparam logic [4:0] DEF_HPC = 5'h10;
	localparam logic [15:0] MAX_CYL = 16'hFFFF;
	localparam logic [27:0] DEF_CAPACITY = 28'h010_0000;
	// Host register file (byte offsets) and fields
	localparam logic [3:0] H_OFF_CTRL = 4'h0;
	localparam logic [3:0] H_OFF_LBA = 4'h4;
	localparam logic [3:0] H_OFF_CMD = 4'h8;
	localparam logic [3:0] H_OFF_STAT = 4'hC;
	localparam int HC_GO = 0;
	localparam int HC_SOFTWARE_RESET_BIT = 1;
	localparam int HC_LINK = 2;
	localparam int HC_PWROFF = 3;
	localparam int HL_MODE = 28;
	localparam logic [31:0] H_RST_REG = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PM_ACTIVE, PM_IDLE, PM_STBY, PM_SLEEP} arsb_pmode_e;
	typedef enum logic [1:0] {K_POR, K_LINK, K_SOFT, K_DIAG} arsb_kind_e;

	function automatic logic [27:0] arsb_chs2lba(input logic [15:0] c, input logic [3:0] h,
		input logic [7:0] s, input logic [4:0] hpc, input logic [7:0] spt);
		logic [31:0] t;
		t = ({16'h0000, c} * {27'h000_0000, hpc} + {28'h000_0000, h}) * {24'h00_0000, spt}
			+ {24'h00_0000, s} - 32'h0000_0001;
		return t[27:0];
	endfunction
endpackage
`default_nettype wire

// ---- rtl/arsb_if.sv ----
/*
 Task-register link between host controller and drive end.
 Assumes both ends run on the same aclk; no clock inside.
*/
`timescale 1ns/10ps
`default_nettype none
interface arsb_if;
	logic wr;
	logic rd;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	logic link_rst;
	modport dev (input wr, input rd, input addr, input wdata, input link_rst, output rdata, output rvalid);
	modport hst (output wr, output rd, output addr, output wdata, output link_rst, input rdata, input rvalid);
endinterface
`default_nettype wire

// ---- rtl/arsb_host.sv ----
/*
 Host end: AXI4-Lite register file driving command, reset and power-off sequences.
 Assumes the drive end answers a link read one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module arsb_host
	import arsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	arsb_if.hst lnk,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic power_off_ok
);
	typedef enum logic [3:0] {H_IDLE = 4'h1, H_WR = 4'h2, H_POLL = 4'h4, H_WAIT = 4'h8} arsb_hstate_e;

	typedef struct packed {
		arsb_hstate_e st;
		logic software_reset_bit_op;
		logic [2:0] step;
		logic errph;
		logic pwr;
		logic pwr_ok;
		logic [31:0] lba;
		logic [31:0] cmd;
		logic [7:0] last_stat;
		logic [7:0] last_err;
		logic wr;
		logic rd;
		logic link_rst;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic aw_ok;
		logic w_ok;
		logic [3:0] aw_a;
		logic [31:0] w_d;
		logic [3:0] w_s;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} arsb_host_s;

	arsb_host_s h;
	arsb_host_s next_h;
	logic [3:0] it_addr;
	logic [7:0] it_data;
	logic it_last;

	function automatic logic [31:0] arsb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	// Write list of the running sequence
	always_comb
	begin
		it_last = 1'b0;
		it_addr = A_ALTCTL;
		it_data = CTL_SOFTWARE_RESET_BIT_ON;
		if (h.software_reset_bit_op)
		begin
			it_last = h.step == 3'h1;
			it_data = h.step == 3'h0 ? CTL_SOFTWARE_RESET_BIT_ON : CTL_SOFTWARE_RESET_BIT_OFF;
		end
		else
			case (h.step)
				3'h0: {it_addr, it_data} = {A_ERR, h.cmd[23:16]};
				3'h1: {it_addr, it_data} = {A_CNT, h.cmd[15:8]};
				3'h2: {it_addr, it_data} = {A_AD0, h.lba[7:0]};
				3'h3: {it_addr, it_data} = {A_AD1, h.lba[15:8]};
				3'h4: {it_addr, it_data} = {A_AD2, h.lba[23:16]};
				3'h5: {it_addr, it_data} = {A_DH, 1'b1, h.lba[HL_MODE], 2'b10, h.lba[27:24]};
				default:
				begin
					it_last = 1'b1;
					it_addr = A_STCMD;
					it_data = h.pwr ? CMD_STBYI : h.cmd[7:0];
				end
			endcase
	end

	assign s_axi_awready = !h.aw_ok && !h.bvalid;
	assign s_axi_wready = !h.w_ok && !h.bvalid;
	assign s_axi_arready = !h.rvalid;

	always_comb
	begin
		next_h = h;
		next_h.wr = 1'b0;
		next_h.rd = 1'b0;
		next_h.link_rst = 1'b0;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_h.aw_ok = 1'b1;
			next_h.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_h.w_ok = 1'b1;
			next_h.w_d = s_axi_wdata;
			next_h.w_s = s_axi_wstrb;
		end
		if (h.bvalid && s_axi_bready)
			next_h.bvalid = 1'b0;
		if (h.rvalid && s_axi_rready)
			next_h.rvalid = 1'b0;
		case (h.st)
			H_WR:
			begin
				next_h.wr = 1'b1;
				next_h.addr = it_addr;
				next_h.wdata = it_data;
				if (it_last)
					next_h.st = H_POLL;
				else
					next_h.step = h.step + 3'h1;
			end
			H_POLL:
			begin
				next_h.rd = 1'b1;
				next_h.addr = h.errph ? A_ERR : A_ALTCTL;
				next_h.st = H_WAIT;
			end
			H_WAIT:
				if (lnk.rvalid)
				begin
					next_h.st = H_POLL;
					if (h.errph)
					begin
						next_h.last_err = lnk.rdata;
						next_h.errph = 1'b0;
						next_h.pwr = 1'b0;
						next_h.pwr_ok = h.pwr && !h.last_stat[0];
						next_h.st = H_IDLE;
					end
					else if (!lnk.rdata[BSY_BIT])
					begin
						next_h.last_stat = lnk.rdata;
						next_h.errph = 1'b1;
					end
				end
			default:
				next_h.st = H_IDLE;
		endcase
		if (h.aw_ok && h.w_ok && !h.bvalid)
		begin
			next_h.aw_ok = 1'b0;
			next_h.w_ok = 1'b0;
			next_h.bvalid = 1'b1;
			next_h.bresp = RESP_OKAY;
			if (h.aw_a == H_OFF_CTRL)
			begin
				// Orders are dropped while a sequence runs
				if (h.st == H_IDLE && h.w_s[0] && h.w_d[3:0] != 4'h0)
				begin
					next_h.step = 3'h0;
					next_h.pwr_ok = 1'b0;
					next_h.software_reset_bit_op = h.w_d[HC_SOFTWARE_RESET_BIT];
					next_h.pwr = h.w_d[HC_PWROFF];
					next_h.st = H_WR;
					if (h.w_d[HC_LINK])
					begin
						next_h.link_rst = 1'b1;
						next_h.st = H_POLL;
					end
				end
			end
			else if (h.aw_a == H_OFF_LBA)
				next_h.lba = arsb_merge(h.lba, h.w_d, h.w_s);
			else if (h.aw_a == H_OFF_CMD)
				next_h.cmd = arsb_merge(h.cmd, h.w_d, h.w_s);
			else if (h.aw_a != H_OFF_STAT)
				next_h.bresp = RESP_SLVERR;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_h.rvalid = 1'b1;
			next_h.rresp = RESP_OKAY;
			if (s_axi_araddr == H_OFF_CTRL)
				next_h.rdata = H_RST_REG;
			else if (s_axi_araddr == H_OFF_LBA)
				next_h.rdata = h.lba;
			else if (s_axi_araddr == H_OFF_CMD)
				next_h.rdata = h.cmd;
			else if (s_axi_araddr == H_OFF_STAT)
				next_h.rdata = {7'h00, h.pwr_ok, h.last_err, h.last_stat, 7'h00, h.st != H_IDLE};
			else
			begin
				next_h.rdata = H_RST_REG;
				next_h.rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			h <= '0;
			h.st <= H_IDLE;
		end
		else
			h <= next_h;
	end

	assign lnk.wr = h.wr;
	assign lnk.rd = h.rd;
	assign lnk.addr = h.addr;
	assign lnk.wdata = h.wdata;
	assign lnk.link_rst = h.link_rst;
	assign s_axi_bvalid = h.bvalid;
	assign s_axi_bresp = h.bresp;
	assign s_axi_rvalid = h.rvalid;
	assign s_axi_rdata = h.rdata;
	assign s_axi_rresp = h.rresp;
	assign power_off_ok = h.pwr_ok;
endmodule // arsb_host
`default_nettype wire

// ---- testbench/arsb_link_sva.sv ----
/*
 Checker on the task-register link between host end and drive end.
 Assumes plain link signals as inputs and one clock for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module arsb_link_sva
	import arsb_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr,
	input wire logic rd,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic link_rst
);
	logic [3:0] last_addr;
	logic [3:0] next_last_addr;
	always_comb
	begin
		next_last_addr = rd ? addr : last_addr;
	end
	always_ff @(posedge aclk)
	begin
		last_addr <= aresetn ? next_last_addr : 4'h0;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rd_answer; rd |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("link read not answered");
	property p_rvalid_cause; rvalid |-> $past(rd); endproperty
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
	property p_software_reset_bit_pair;
		wr && addr == A_ALTCTL && wdata == CTL_SOFTWARE_RESET_BIT_ON |=> wr && addr == A_ALTCTL && wdata == CTL_SOFTWARE_RESET_BIT_OFF;
	endproperty
	a_software_reset_bit_pair: assert property (p_software_reset_bit_pair) else $error("reset bit not cleared after set");
	property p_software_reset_bit_busy;
		(wr && addr == A_ALTCTL && wdata == CTL_SOFTWARE_RESET_BIT_OFF) ##1 rd |=> rvalid && rdata[BSY_BIT];
	endproperty
	a_software_reset_bit_busy: assert property (p_software_reset_bit_busy) else $error("busy not shown during reset");
	property p_ready_bits;
		rvalid && !rdata[BSY_BIT] && (last_addr == A_STCMD || last_addr == A_ALTCTL) |-> rdata[6] && rdata[4];
	endproperty
	a_ready_bits: assert property (p_ready_bits) else $error("ready or seek flag missing");
	property p_link_pulse; link_rst |=> !link_rst; endproperty
	a_link_pulse: assert property (p_link_pulse) else $error("link reset longer than one cycle");
	property p_dh_form; wr && addr == A_DH |-> wdata[7] && wdata[5] && !wdata[4]; endproperty
	a_dh_form: assert property (p_dh_form) else $error("device head byte malformed");
	property p_dh_cmd; wr && addr == A_DH |=> wr && addr == A_STCMD; endproperty
	a_dh_cmd: assert property (p_dh_cmd) else $error("command not after device head");
	c_link: cover property (link_rst);
	c_software_reset_bit: cover property (wr && addr == A_ALTCTL && wdata == CTL_SOFTWARE_RESET_BIT_ON);
	c_ready: cover property (rvalid && rdata == RST_STAT);
endmodule // arsb_link_sva
`default_nettype wire

// ---- testbench/tb.sv ----
/*
 Self-checking bench: host end and drive end joined over the link.
 Assumes AXI4-Lite traffic from here and a simple media side model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import arsb_pkg::*; ;
	localparam logic [27:0] CAP = 28'h000_2000;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, power_off_ok;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [7:0] diag_code = 8'h01, media_cmd, cur_spt, def_spt;
	logic diag_done = 1'b1, cache_dirty = 1'b0, unload_done = 1'b0, unl_seen = 1'b0;
	logic diag_req, flush_req, unload_req, hw_init, spin_up, timer_reset, setmax_clear;
	logic settings_revert, abort_host, media_req;
	arsb_pmode_e power_mode;
	logic [27:0] media_lba, m_lba;
	logic [4:0] cur_hpc, def_hpc;
	logic [15:0] cur_cyl, def_cyl;
	logic [31:0] st, w;
	int bad_count = 0, n_tests = 0, cyc = 0, fl = 0;
	int cnt_hw = 0, cnt_spin = 0, cnt_tmr = 0, cnt_smx = 0, spt = 63, hpc = 16, cyl, l, c, h, s;
	int cnt_rev = 0, cnt_abt = 0;
	arsb_if lnk ();
	arsb_device #(.CAPACITY(CAP)) u_arsb_device (.aclk, .aresetn, .lnk(lnk), .power_up_standby(1'b0),
		.diag_code, .diag_done, .cache_dirty, .unload_done, .diag_req, .flush_req, .unload_req, .hw_init,
		.spin_up, .timer_reset, .setmax_clear, .settings_revert, .abort_host, .power_mode, .media_req,
		.media_cmd, .media_lba, .cur_spt, .cur_hpc, .cur_cyl, .def_spt, .def_hpc, .def_cyl);
	arsb_host u_arsb_host (.aclk, .aresetn, .lnk(lnk), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .power_off_ok);
	arsb_link_sva u_arsb_link_sva (.aclk, .aresetn, .wr(lnk.wr), .rd(lnk.rd), .addr(lnk.addr),
		.wdata(lnk.wdata), .rdata(lnk.rdata), .rvalid(lnk.rvalid), .link_rst(lnk.link_rst));
	always #25 aclk = ~aclk;
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Media side: cache flushes after a few cycles, heads unload one cycle after request
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			conclude;
		end
		unload_done <= unload_req;
		unl_seen <= unl_seen | unload_done;
		fl <= (flush_req && cache_dirty) ? fl + 1 : 0;
		if (fl == 4)
			cache_dirty <= 1'b0;
		if (unload_req && cache_dirty)
			chk("unload_clean", 0, 1);
		if (media_req)
			m_lba <= media_lba;
		if (aresetn)
		begin
			cnt_hw += hw_init;
			cnt_spin += spin_up;
			cnt_tmr += timer_reset;
			cnt_smx += setmax_clear;
			cnt_rev += settings_revert;
			cnt_abt += abort_host;
		end
	end
	// Handshake sampled at the falling edge, acted on after the rising one
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb_;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb_ = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		while (tb_ !== 1'b1);
		s_axi_bready <= 1'b0;
		// Idle edge so the next call never re-raises in the same step
		@(posedge aclk);
	endtask
	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, rv;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		while (rv !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic waitidle;
		do
			axr(H_OFF_STAT, st, rs);
		while (st[0] !== 1'b0);
	endtask
	task automatic go(input logic [31:0] lw, input logic [31:0] cw);
		axw(H_OFF_LBA, lw, rs);
		axw(H_OFF_CMD, cw, rs);
		axw(H_OFF_CTRL, 32'h0000_0001, rs);
		waitidle;
	endtask
	task automatic ctl(input int b);
		axw(H_OFF_CTRL, 32'h0000_0001 << b, rs);
		waitidle;
	endtask
	task automatic xfer;
		for (int i = 0; i < 6; i++)
		begin
			c = $urandom % cyl;
			h = $urandom % hpc;
			s = $urandom % spt + 1;
			l = i[0] ? (c * hpc + h) * spt + s - 1 : $urandom % CAP;
			w = i[0] ? {4'h0, h[3:0], c[15:0], s[7:0]} : {3'b000, 1'b1, l[27:0]};
			go(w, 32'h0000_0120);
			chk("media_lba", l, m_lba);
			chk("media_cmd", 32'h0000_0020, media_cmd);
		end
	endtask
	task automatic xlat;
		cyl = CAP / (spt * hpc);
		chk("cur_spt", spt, cur_spt);
		chk("cur_hpc", hpc, cur_hpc);
		chk("cur_cyl", cyl, cur_cyl);
	endtask
	initial
	begin
		void'($urandom(55));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// Host polls out power-on work; an earlier reset would cut the cylinder count
		go(32'h0000_0000, {24'h00_0000, CMD_IDLE});
		chk("mode_idle", PM_IDLE, power_mode);
		ctl(HC_SOFTWARE_RESET_BIT);
		chk("status", RST_STAT, st[15:8]);
		chk("error", DIAG_OK, st[23:16]);
		chk("hw_init", 1, cnt_hw);
		chk("spin_up", 1, cnt_spin);
		chk("timer", 1, cnt_tmr);
		chk("setmax", 1, cnt_smx);
		chk("revert", 1, cnt_rev);
		chk("abort", 1, cnt_abt);
		$display("test power-on and soft reset done");
		ctl(HC_LINK);
		chk("status", RST_STAT, st[15:8]);
		chk("hw_init", 1, cnt_hw);
		chk("timer", 2, cnt_tmr);
		chk("setmax", 1, cnt_smx);
		chk("abort", 2, cnt_abt);
		$display("test link reset done");
		for (int k = 5; k > 0; k--)
		begin
			diag_code <= k[7:0];
			go(32'h0000_0000, {24'h00_0000, CMD_DIAG});
			chk("diag_error", k, st[23:16]);
		end
		$display("test diagnostic codes done");
		xlat;
		chk("def_cyl", cyl, def_cyl);
		xfer;
		for (int j = 0; j < 2; j++)
		begin
			go({8'h00, j[0] ? cyl[15:0] : 16'h0000, j[0] ? 8'h01 : 8'h00}, 32'h0000_0120);
			chk("range_status", STAT_ERR, st[15:8]);
			chk("range_error", ERR_ABORT, st[23:16]);
		end
		$display("test default translation done");
		go(32'h0300_0000, {16'h0000, 8'h11, CMD_INITP});
		spt = 17;
		hpc = 4;
		xlat;
		xfer;
		ctl(HC_SOFTWARE_RESET_BIT);
		xlat;
		chk("revert", 1, cnt_rev);
		go(32'h0000_0000, {8'h00, FEAT_REVERT_ON, 8'h00, CMD_SETF});
		ctl(HC_SOFTWARE_RESET_BIT);
		spt = 63;
		hpc = 16;
		xlat;
		chk("revert", 2, cnt_rev);
		$display("test translation change done");
		go(32'h0000_0000, {24'h00_0000, CMD_SLEEP});
		chk("mode_sleep", PM_SLEEP, power_mode);
		ctl(HC_LINK);
		chk("mode_wake", PM_STBY, power_mode);
		cache_dirty <= 1'b1;
		unl_seen <= 1'b0;
		ctl(HC_PWROFF);
		chk("power_off_ok", 1, st[24]);
		chk("unloaded", 1, unl_seen);
		chk("mode_stby", PM_STBY, power_mode);
		axr(4'h2, st, rs);
		chk("unmapped_resp", RESP_SLVERR, rs);
		$display("test power modes done");
		conclude;
	end
endmodule // tb
`default_nettype wire
